// ### inc/fractional_simd_pkg.sv
// Overview of operation
// RULE_01: abs of low word, sign-extended to 64
// RULE_02: input 0x80000000 yields 0x7FFFFFFF
// RULE_03: saturating abs sets overflow bit 20
// RULE_04: wrapping adds keep truncated two's-complement sum
// RULE_05: halfword saturation clamps to 0x7FFF/0x8000
// RULE_06: pair-half adds, upper 32 bits sign-filled
// RULE_07: any element overflow sets bit 20
// RULE_08: halfword overflow from 17-bit sum bits 16,15
// RULE_09: pair-word adds fill full 64 bits
// RULE_10: word overflow from 33-bit sum, clamp, flag
// RULE_11: quad-half adds, four independent lanes
// RULE_12: abs decode: major, zero rs, sub/func codes
// RULE_13: pair-half add: func 010000, sub 01010/01110
// RULE_14: pair-word add: func 010100, sub 10010/10110
// RULE_15: quad-half add: func 010100, sub 01010/01110
// RULE_16: no data-dependent exceptions raised
// RULE_17: flag only set, other control bits kept
// RULE_18: extension disabled: no write, raise exception
package fractional_simd_pkg;

  // data widths
  localparam int DATA_W  = 64;
  localparam int WORD_W  = 32;
  localparam int HALF_W  = 16;
  localparam int REG_IDX_W = 5;

  // instruction field positions
  localparam int MAJOR_LSB  = 26;
  localparam int FIRST_LSB  = 21;
  localparam int SECOND_LSB = 16;
  localparam int DEST_LSB   = 11;
  localparam int SUB_LSB    = 6;
  localparam int FUNC_LSB   = 0;

  // opcode values
  localparam logic [5:0] EXTENSION_MAJOR_OPCODE     = 6'h1F;
  localparam logic [5:0] ABS_FAMILY_FUNCTION_CODE   = 6'h12;
  localparam logic [5:0] ADD_FAMILY_FUNCTION_CODE_A = 6'h10;
  localparam logic [5:0] ADD_FAMILY_FUNCTION_CODE_B = 6'h14;
  localparam logic [4:0] SUB_SAT_ABS_WORD  = 5'h11;
  localparam logic [4:0] SUB_WRAP_HALF     = 5'h0A;
  localparam logic [4:0] SUB_SAT_HALF      = 5'h0E;
  localparam logic [4:0] SUB_WRAP_WORD     = 5'h12;
  localparam logic [4:0] SUB_SAT_WORD      = 5'h16;

  // control register overflow flag field
  localparam int OUFLAG_BIT = 20;
  localparam int CTRL_W     = 32;

  // fixed-point extremes
  localparam logic [31:0] WORD_MIN = 32'h80000000;
  localparam logic [31:0] WORD_MAX = 32'h7FFFFFFF;
  localparam logic [15:0] HALF_MIN = 16'h8000;
  localparam logic [15:0] HALF_MAX = 16'h7FFF;

  // reset values
  localparam logic [63:0] RESULT_RST = 64'h0;
  localparam logic [31:0] CTRL_RST   = 32'h0;
  localparam logic [4:0]  IDX_RST    = 5'h0;

  // decoded operation
  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_ABS_W  = 3'b001,
    OP_ADD_PH = 3'b010,
    OP_ADD_PW = 3'b011,
    OP_ADD_QH = 3'b100
  } op_t;

endpackage

// ### inc/simd_decode_if.sv
`timescale 1ns/1ps
// decoded operation handed from decoder to datapath
interface simd_decode_if;
  fractional_simd_pkg::op_t op;  // operation class
  logic                     sat; // saturating form
  logic [4:0]               dest; // destination index
  modport producer (output op, output sat, output dest);
  modport consumer (input op, input sat, input dest);
endinterface

// ### hdl/simd_decoder.sv
`timescale 1ns/1ps
// pure decode of one instruction word into an operation class
module simd_decoder (
  input  wire logic [31:0]       instr,
  simd_decode_if.producer        dec
);

  logic [5:0] major;  // major opcode field
  logic [4:0] first;  // first source index
  logic [4:0] sub;    // sub-operation
  logic [5:0] func;   // function code

  assign major = instr[fractional_simd_pkg::MAJOR_LSB +: 6];
  assign first = instr[fractional_simd_pkg::FIRST_LSB +: 5];
  assign sub   = instr[fractional_simd_pkg::SUB_LSB +: 5];
  assign func  = instr[fractional_simd_pkg::FUNC_LSB +: 6];

  // classify; unknown codes fall to none so others may claim them
  always_comb begin
    dec.op   = fractional_simd_pkg::OP_NONE;
    dec.sat  = 1'b0;
    dec.dest = instr[fractional_simd_pkg::DEST_LSB +: 5];
    if (major == fractional_simd_pkg::EXTENSION_MAJOR_OPCODE) begin
      if (func == fractional_simd_pkg::ABS_FAMILY_FUNCTION_CODE &&
          sub == fractional_simd_pkg::SUB_SAT_ABS_WORD &&
          first == 5'h00) begin
        dec.op  = fractional_simd_pkg::OP_ABS_W; // RULE_12
        dec.sat = 1'b1;
      end else if (func ==
                   fractional_simd_pkg::ADD_FAMILY_FUNCTION_CODE_A) begin
        if (sub == fractional_simd_pkg::SUB_WRAP_HALF ||
            sub == fractional_simd_pkg::SUB_SAT_HALF) begin
          dec.op  = fractional_simd_pkg::OP_ADD_PH; // RULE_13
          dec.sat = (sub == fractional_simd_pkg::SUB_SAT_HALF);
        end
      end else if (func ==
                   fractional_simd_pkg::ADD_FAMILY_FUNCTION_CODE_B) begin
        // same sub codes as pair-half, told apart by func only
        if (sub == fractional_simd_pkg::SUB_WRAP_HALF ||
            sub == fractional_simd_pkg::SUB_SAT_HALF) begin
          dec.op  = fractional_simd_pkg::OP_ADD_QH; // RULE_15
          dec.sat = (sub == fractional_simd_pkg::SUB_SAT_HALF);
        end else if (sub == fractional_simd_pkg::SUB_WRAP_WORD ||
                     sub == fractional_simd_pkg::SUB_SAT_WORD) begin
          dec.op  = fractional_simd_pkg::OP_ADD_PW; // RULE_14
          dec.sat = (sub == fractional_simd_pkg::SUB_SAT_WORD);
        end
      end
    end
  end

endmodule

// ### hdl/sat_lane_adder.sv
`timescale 1ns/1ps
// one signed fractional lane: wrap or saturate, with overflow out
module sat_lane_adder #(
  parameter int WIDTH = 16
) (
  input  wire logic [WIDTH-1:0] a,
  input  wire logic [WIDTH-1:0] b,
  input  wire logic             sat,
  output logic      [WIDTH-1:0] sum,
  output logic                  ovf
);

  logic [WIDTH:0] wide; // one guard bit above the lane

  // guard bit differing from the lane sign means out of range
  always_comb begin
    wide = {a[WIDTH-1], a} + {b[WIDTH-1], b}; // RULE_08 RULE_10
    ovf  = wide[WIDTH] ^ wide[WIDTH-1];
    sum  = wide[WIDTH-1:0]; // RULE_04
    if (ovf && sat) begin
      // guard clear: positive overflow; set: negative
      sum = wide[WIDTH] ? {1'b1, {(WIDTH-1){1'b0}}}
                        : {1'b0, {(WIDTH-1){1'b1}}}; // RULE_05 RULE_10
    end
  end

endmodule

// ### hdl/fractional_abs_add_simd_unit.sv
`timescale 1ns/1ps
// one-stage fractional abs/add unit for the signal-processing
// extension. operands arrive with the instruction word; the
// result, its destination index and the updated control word
// leave one enabled clock later, all from flops.
module fractional_abs_add_simd_unit (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        issue_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [63:0] first_src_data,
  input  wire logic [63:0] second_src_data,
  input  wire logic        ext_enabled,
  input  wire logic [31:0] sp_control_in,
  output logic             claimed_q,
  output logic             result_valid_q,
  output logic [63:0]      result_q,
  output logic [4:0]       dest_idx_q,
  output logic             ctrl_we_q,
  output logic [31:0]      sp_control_out_q,
  output logic             ouflag_set_q,
  output logic             ext_disabled_exc_q
);

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------

  simd_decode_if dec (); // decoded class, form and destination

  // decoder is pure logic; the stage register sits below
  simd_decoder u_decoder (
    .instr (instr_word),
    .dec   (dec)
  );

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------

  // saturating magnitude of a Q31 word; sets sat on the minimum
  function automatic logic [32:0] sat_abs_word(
    input logic [31:0] a
  );
    logic [31:0] mag;
    logic        hit;
    mag = a;
    hit = 1'b0;
    if (a == fractional_simd_pkg::WORD_MIN) begin
      // negation would wrap back to the minimum
      mag = fractional_simd_pkg::WORD_MAX; // RULE_02
      hit = 1'b1;
    end else if (a[31]) begin
      mag = 32'h00000000 - a;
    end
    return {hit, mag};
  endfunction

  // sign-fill a low word into the full register width
  function automatic logic [63:0] sext_word(
    input logic [31:0] w
  );
    return {{32{w[31]}}, w};
  endfunction

  // ------------------------------------------------------------
  // lane adders
  // ------------------------------------------------------------

  logic [15:0] half_sum [4]; // four halfword lane results
  logic [3:0]  half_ovf;     // halfword lane out-of-range
  logic [31:0] word_sum [2]; // two word lane results
  logic [1:0]  word_ovf;     // word lane out-of-range

  // four independent halfword lanes, each in its own slot
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_half
      sat_lane_adder #(
        .WIDTH (fractional_simd_pkg::HALF_W)
      ) u_half (
        .a   (first_src_data[16*g +: 16]),
        .b   (second_src_data[16*g +: 16]),
        .sat (dec.sat),
        .sum (half_sum[g]),
        .ovf (half_ovf[g])
      ); // RULE_11
    end
    // two independent word lanes
    for (g = 0; g < 2; g++) begin : g_word
      sat_lane_adder #(
        .WIDTH (fractional_simd_pkg::WORD_W)
      ) u_word (
        .a   (first_src_data[32*g +: 32]),
        .b   (second_src_data[32*g +: 32]),
        .sat (dec.sat),
        .sum (word_sum[g]),
        .ovf (word_ovf[g])
      ); // RULE_09
    end
  endgenerate

  // ------------------------------------------------------------
  // result selection
  // ------------------------------------------------------------

  logic [32:0] abs_res;  // flag and magnitude of low word
  logic [63:0] op_res;   // selected 64-bit result
  logic        op_ovf;   // any element out of range
  logic        op_hit;   // instruction belongs to this unit

  // pick the result of the decoded class
  always_comb begin
    abs_res = sat_abs_word(second_src_data[31:0]);
    op_res  = fractional_simd_pkg::RESULT_RST;
    op_ovf  = 1'b0;
    op_hit  = 1'b1;
    unique case (dec.op)
      fractional_simd_pkg::OP_ABS_W: begin
        // only the low word of the second source matters
        op_res = sext_word(abs_res[31:0]); // RULE_01
        op_ovf = abs_res[32]; // RULE_03
      end
      fractional_simd_pkg::OP_ADD_PH: begin
        // upper half of the register carries the top lane sign
        op_res = {{32{half_sum[1][15]}},
                  half_sum[1], half_sum[0]}; // RULE_06
        op_ovf = |half_ovf[1:0]; // RULE_07
      end
      fractional_simd_pkg::OP_ADD_PW: begin
        // no sign fill: both words occupy the register
        op_res = {word_sum[1], word_sum[0]}; // RULE_09
        op_ovf = |word_ovf; // RULE_07
      end
      fractional_simd_pkg::OP_ADD_QH: begin
        op_res = {half_sum[3], half_sum[2],
                  half_sum[1], half_sum[0]}; // RULE_11
        op_ovf = |half_ovf; // RULE_07
      end
      fractional_simd_pkg::OP_NONE: begin
        // not ours: another unit or the reserved trap handles it
        op_hit = 1'b0;
      end
      default: begin
        // unused enum codes; nothing claimed
        op_hit = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // issue qualification
  // ------------------------------------------------------------

  logic take;     // valid instruction of ours this cycle
  logic do_write; // allowed to write back
  logic do_trap;  // extension switched off

  // gate write-back on the enable; trap instead when off
  always_comb begin
    take     = issue_valid && op_hit;
    do_write = take && ext_enabled;
    do_trap  = take && !ext_enabled; // RULE_18
  end

  // ------------------------------------------------------------
  // control word update
  // ------------------------------------------------------------

  logic [31:0] ctrl_next; // control word after this instruction

  // flag is only ever or-ed in; the rest pass through untouched
  always_comb begin
    ctrl_next = sp_control_in; // RULE_17
    if (do_write && op_ovf) begin
      ctrl_next[fractional_simd_pkg::OUFLAG_BIT] = 1'b1; // RULE_07
    end
  end

  // ------------------------------------------------------------
  // output stage next values
  // ------------------------------------------------------------

  logic        claimed_d;      // instruction was ours
  logic        result_valid_d; // write-back strobe
  logic [63:0] result_d;       // write-back data
  logic [4:0]  dest_idx_d;     // write-back index
  logic        ctrl_we_d;      // control word write strobe
  logic [31:0] sp_control_d;   // control word to write
  logic        ouflag_set_d;   // flag was raised this op
  logic        ext_exc_d;      // extension-disabled trap

  // next values; data are held when nothing is issued so that
  // the outputs do not toggle needlessly
  always_comb begin
    claimed_d      = take;
    result_valid_d = do_write;
    result_d       = result_q;
    dest_idx_d     = dest_idx_q;
    ctrl_we_d      = do_write;
    sp_control_d   = sp_control_out_q;
    ouflag_set_d   = do_write && op_ovf;
    // only trap possible here; data never raise one
    ext_exc_d      = do_trap; // RULE_16
    if (do_write) begin
      result_d     = op_res;
      dest_idx_d   = dec.dest;
      sp_control_d = ctrl_next;
    end else if (do_trap) begin
      // suppress the write, keep stale data off the strobes
      result_d     = result_q; // RULE_18
    end
  end

  // ------------------------------------------------------------
  // output stage registers
  // ------------------------------------------------------------

  // clk_en low freezes every flop, strobes included
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      claimed_q          <= 1'b0;
      result_valid_q     <= 1'b0;
      result_q           <= fractional_simd_pkg::RESULT_RST;
      dest_idx_q         <= fractional_simd_pkg::IDX_RST;
      ctrl_we_q          <= 1'b0;
      sp_control_out_q   <= fractional_simd_pkg::CTRL_RST;
      ouflag_set_q       <= 1'b0;
      ext_disabled_exc_q <= 1'b0;
    end else if (clk_en) begin
      claimed_q          <= claimed_d;
      result_valid_q     <= result_valid_d;
      result_q           <= result_d;
      dest_idx_q         <= dest_idx_d;
      ctrl_we_q          <= ctrl_we_d;
      sp_control_out_q   <= sp_control_d;
      ouflag_set_q       <= ouflag_set_d;
      ext_disabled_exc_q <= ext_exc_d;
    end
  end

endmodule

// ### test/fractional_simd_properties.sv
`timescale 1ns/1ps
// port-level relations of the abs/add unit, one enabled edge apart or, for the a_off_no_write and a_flag_in_ctrl checks, in one cycle
module fractional_simd_properties (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        clk_en,
  input wire logic        issue_valid,
  input wire logic [31:0] instr_word,
  input wire logic [63:0] first_src_data,
  input wire logic [63:0] second_src_data,
  input wire logic        ext_enabled,
  input wire logic [31:0] sp_control_in,
  input wire logic        claimed_q,
  input wire logic        result_valid_q,
  input wire logic [63:0] result_q,
  input wire logic [4:0]  dest_idx_q,
  input wire logic        ctrl_we_q,
  input wire logic [31:0] sp_control_out_q,
  input wire logic        ouflag_set_q,
  input wire logic        ext_disabled_exc_q
);
  localparam logic [31:0] FLAG_M = 32'h0010_0000; // overflow flag mask
  logic        major_ok; // major opcode matches
  logic        is_abs;   // single-word abs, first source zero
  logic        rec;      // one of the claimed words
  logic        took;     // recognised word issued
  logic        took_on;  // issued with extension on
  logic        took_off; // issued with extension off
  logic        abs_min;  // abs input is the most negative word
  logic [4:0]  dest_f;   // destination field
  logic [31:0] abs_exp;  // expected magnitude

  // decode kept apart from the design so a decode slip shows up
  assign major_ok = instr_word[31:26] == 6'h1F;
  assign is_abs = major_ok && instr_word[5:0] == 6'h12
               && instr_word[10:6] == 5'h11 && instr_word[25:21] == 5'h00;
  assign rec = is_abs || (major_ok && instr_word[5:0] == 6'h10
               && (instr_word[10:6] == 5'h0A || instr_word[10:6] == 5'h0E))
               || (major_ok && instr_word[5:0] == 6'h14
               && (instr_word[10:6] == 5'h0A || instr_word[10:6] == 5'h0E
               || instr_word[10:6] == 5'h12 || instr_word[10:6] == 5'h16));
  assign took = issue_valid && rec;
  assign took_on = took && ext_enabled;
  assign took_off = took && !ext_enabled;
  assign abs_min = second_src_data[31:0] == 32'h8000_0000;
  assign dest_f = instr_word[15:11];

  // magnitude with the single saturating case
  always_comb begin
    if (abs_min)
      abs_exp = 32'h7FFF_FFFF;
    else if (second_src_data[31])
      abs_exp = -second_src_data[31:0];
    else
      abs_exp = second_src_data[31:0];
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_claim_follows_issue: assert property (
    clk_en |=> claimed_q == $past(took)) else $error("claim mismatch");
  a_write_when_on: assert property (
    clk_en |=> result_valid_q == $past(took_on) && ctrl_we_q == result_valid_q)
    else $error("write strobe mismatch");
  a_exc_only_off: assert property (
    clk_en |=> ext_disabled_exc_q == $past(took_off))
    else $error("exception strobe mismatch");
  a_off_no_write: assert property (
    ext_disabled_exc_q |-> !result_valid_q && !ouflag_set_q && !ctrl_we_q)
    else $error("write while extension off");
  a_other_bits_kept: assert property (
    clk_en && took_on |=> (sp_control_out_q & ~FLAG_M)
      == ($past(sp_control_in) & ~FLAG_M)
      && (sp_control_out_q & $past(sp_control_in)) == $past(sp_control_in))
    else $error("control bits disturbed");
  a_flag_in_ctrl: assert property (
    ouflag_set_q |-> sp_control_out_q[20] && ctrl_we_q)
    else $error("flag not written");
  a_abs_magnitude: assert property (
    clk_en && took_on && is_abs |=> result_q == {32'h0000_0000, $past(abs_exp)})
    else $error("abs result wrong");
  a_abs_sat_flag: assert property (
    clk_en && took_on && is_abs |=> ouflag_set_q == $past(abs_min))
    else $error("abs flag wrong");
  a_dest_follows: assert property (
    clk_en && took_on |=> dest_idx_q == $past(dest_f))
    else $error("destination index wrong");

  c_abs_sat: cover property (clk_en && took_on && is_abs && abs_min);
  c_flagged: cover property (ouflag_set_q && result_valid_q);
  c_off: cover property (ext_disabled_exc_q);
  c_frozen: cover property (!clk_en && result_valid_q);
endmodule

// ### test/core_ctrl_model.sv
`timescale 1ns/1ps
// core side: owns the control register and forwards a fresh write
module core_ctrl_model #(
  parameter logic [31:0] CTRL_INIT = 32'h00C0_0005 // other bits set on purpose
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        ctrl_we,
  input  wire logic [31:0] ctrl_wdata,
  output logic      [31:0] ctrl_rdata
);
  logic [31:0] ctrl_q; // held control word
  logic [31:0] ctrl_d; // next control word

  // bypass so back-to-back ops see the previous update
  always_comb ctrl_d = ctrl_we ? ctrl_wdata : ctrl_q;
  assign ctrl_rdata = ctrl_d;

  // register only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      ctrl_q <= CTRL_INIT;
    else
      ctrl_q <= ctrl_d;
  end
endmodule

// ### test/fractional_abs_add_simd_unit_test.sv
`timescale 1ns/1ps
// random back-to-back ops checked each edge against a reference
module fractional_abs_add_simd_unit_test;
  localparam logic [31:0] CTRL_INIT = 32'h00C0_0005;
  localparam logic [5:0] FN [9] = '{6'h12, 6'h10, 6'h10, 6'h14, 6'h14,
                                    6'h14, 6'h14, 6'h12, 6'h14};
  localparam logic [4:0] SB [9] = '{5'h11, 5'h0A, 5'h0E, 5'h12, 5'h16,
                                    5'h0A, 5'h0E, 5'h11, 5'h01};
  logic clk_sys, rst_b, clk_en, issue_valid, ext_enabled;
  logic claimed_q, result_valid_q, ctrl_we_q, ouflag_set_q, ext_disabled_exc_q;
  logic [31:0] instr_word, sp_control_in, sp_control_out_q, s_ins, e_ctl, m_ctl;
  logic [63:0] first_src_data, second_src_data, result_q, s_a, s_b, e_res;
  logic [4:0]  dest_idx_q, e_dst;
  logic        s_en, s_vld, s_ext, e_clm, e_rv, e_exc, e_of;
  int          s_k, err_total, cmp_count;

  fractional_abs_add_simd_unit u_fractional_abs_add_simd_unit (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .issue_valid(issue_valid), .instr_word(instr_word),
    .first_src_data(first_src_data), .second_src_data(second_src_data),
    .ext_enabled(ext_enabled), .sp_control_in(sp_control_in),
    .claimed_q(claimed_q), .result_valid_q(result_valid_q),
    .result_q(result_q), .dest_idx_q(dest_idx_q), .ctrl_we_q(ctrl_we_q),
    .sp_control_out_q(sp_control_out_q), .ouflag_set_q(ouflag_set_q),
    .ext_disabled_exc_q(ext_disabled_exc_q));
  core_ctrl_model #(.CTRL_INIT(CTRL_INIT)) u_core_ctrl_model (
    .clk_sys(clk_sys), .rst_b(rst_b), .ctrl_we(ctrl_we_q),
    .ctrl_wdata(sp_control_out_q), .ctrl_rdata(sp_control_in));

  // one signed lane, wrapped or clamped, flag on overflow
  function automatic logic [31:0] lane(int w, logic [31:0] x, y, bit s,
                                       inout bit ov);
    longint m, t;
    m = longint'(1) << (w - 1);
    t = (x[w-1] ? longint'(x) - 2 * m : longint'(x))
      + (y[w-1] ? longint'(y) - 2 * m : longint'(y));
    if (t >= m || t < -m) begin
      ov = 1;
      if (s) t = (t > 0) ? m - 1 : -m;
    end
    return 32'(t) & 32'(2 * m - 1);
  endfunction

  // reference result for kinds 0..6
  function automatic logic [63:0] run_op(int k, logic [63:0] a, b,
                                         inout bit ov);
    logic [63:0] r;
    bit s;
    s = (k == 2 || k == 4 || k == 6);
    r = '0;
    if (k == 0) begin
      if (b[31:0] == 32'h8000_0000) begin
        r[31:0] = 32'h7FFF_FFFF;
        ov = 1;
      end else r[31:0] = b[31] ? -b[31:0] : b[31:0];
    end else if (k <= 2) begin
      for (int i = 0; i < 2; i++)
        r[16*i+:16] = 16'(lane(16, 32'(a[16*i+:16]), 32'(b[16*i+:16]), s, ov));
      r[63:32] = {32{r[31]}};
    end else if (k <= 4) begin
      for (int i = 0; i < 2; i++)
        r[32*i+:32] = lane(32, a[32*i+:32], b[32*i+:32], s, ov);
    end else begin
      for (int i = 0; i < 4; i++)
        r[16*i+:16] = 16'(lane(16, 32'(a[16*i+:16]), 32'(b[16*i+:16]), s, ov));
    end
    return r;
  endfunction

  // operand words biased toward the clamp boundaries
  function automatic logic [31:0] pick();
    case ($urandom % 6)
      0: return 32'h8000_0000;
      1: return 32'h7FFF_FFFF;
      2: return 32'h7FFF_8000;
      3: return 32'h8001_7FFF;
      default: return $urandom;
    endcase
  endfunction

  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one edge: fold taken inputs into the model, drive new ones, compare
  task automatic step();
    bit ov;
    @(posedge clk_sys);
    if (s_en) begin
      e_clm = s_vld && s_k < 7;
      e_rv = 0;
      e_exc = 0;
      e_of = 0;
      if (e_clm && s_ext) begin
        ov = 0;
        e_res = run_op(s_k, s_a, s_b, ov);
        e_dst = s_ins[15:11];
        m_ctl = m_ctl | (32'(ov) << 20);
        e_ctl = m_ctl;
        e_rv = 1;
        e_of = ov;
      end else if (e_clm) e_exc = 1;
    end
    s_k = $urandom % 9;
    s_en = ($urandom % 8) != 0;
    s_vld = ($urandom % 6) != 0;
    s_ext = ($urandom % 10) != 0;
    s_ins = {6'h1F, s_k == 0 ? 5'h00 : 5'($urandom) | 5'h01, 5'($urandom),
             5'($urandom), SB[s_k], FN[s_k]};
    s_a = {pick(), pick()};
    s_b = {pick(), pick()};
    clk_en <= s_en;
    issue_valid <= s_vld;
    ext_enabled <= s_ext;
    instr_word <= s_ins;
    first_src_data <= s_a;
    second_src_data <= s_b;
    #1;
    chk("claimed", claimed_q, e_clm);
    chk("result_valid", result_valid_q, e_rv);
    chk("ctrl_we", ctrl_we_q, e_rv);
    chk("exception", ext_disabled_exc_q, e_exc);
    chk("ouflag_set", ouflag_set_q, e_of);
    chk("result", result_q, e_res);
    chk("dest", dest_idx_q, e_dst);
    chk("control_out", sp_control_out_q, e_ctl);
  endtask

  task automatic clear_model();
    {s_en, e_clm, e_rv, e_exc, e_of} = '0;
    e_res = '0;
    e_dst = '0;
    e_ctl = '0;
    m_ctl = CTRL_INIT;
  endtask

  // free-running system clock
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  // cut a hang short
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end

  // main sequence
  initial begin
    {rst_b, clk_en, issue_valid, ext_enabled} = '0;
    instr_word = '0;
    first_src_data = '0;
    second_src_data = '0;
    {err_total, cmp_count, s_k} = '0;
    clear_model();
    void'($urandom(26));
    repeat (2) @(posedge clk_sys);
    rst_b <= 1;
    repeat (600) step();
    $display("test random ops done");
    @(posedge clk_sys);
    rst_b <= 0;
    clk_en <= 0;
    @(posedge clk_sys);
    #1;
    clear_model();
    chk("reset claimed", claimed_q, 0);
    chk("reset result", result_q, 0);
    chk("reset control", sp_control_out_q, 0);
    // second reset cycle; release lands on an edge like the first one
    @(posedge clk_sys);
    rst_b <= 1;
    $display("test mid-run reset done");
    repeat (300) step();
    $display("test ops after reset done");
    wrap_up();
  end
endmodule

bind fractional_abs_add_simd_unit fractional_simd_properties
  u_fractional_simd_properties (
  .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
  .issue_valid(issue_valid), .instr_word(instr_word),
  .first_src_data(first_src_data), .second_src_data(second_src_data),
  .ext_enabled(ext_enabled), .sp_control_in(sp_control_in),
  .claimed_q(claimed_q), .result_valid_q(result_valid_q),
  .result_q(result_q), .dest_idx_q(dest_idx_q), .ctrl_we_q(ctrl_we_q),
  .sp_control_out_q(sp_control_out_q), .ouflag_set_q(ouflag_set_q),
  .ext_disabled_exc_q(ext_disabled_exc_q));
